// [hdl/etcp_pkg.sv]
// Package: register map, field positions, reset values and modes of the enhanced timer
// Overview of operation
// - Compare mode: action 00 none, 01 low, 10 high, 11 toggle on match.
// - PWM mode: action 00 inactive, 01 active, 10 PWM, 11 single pulse.
// - Capture mode: action selects rising, falling, both or no edge.
// - Match requesting the level already present leaves the pin unchanged.
// - Timer switching on returns compare-mode pins to their initial level.
// - Compare mode: output level bit gives initial low or high.
// - PWM modes: output level bit gives active low or high.
// - Invert bit inverts the channel pin, except in timer/counter mode.
// - Read-only direction flag: 0 counting up, 1 counting down.
// - Clear select 1 clears on compare A, 0 on period match or overflow.
// - Overflow clearing happens only when the period compare value is zero.
// - Clear select is ignored in single pulse and capture modes.
// - Channel B mode: compare, capture, PWM or single pulse, timer/counter.
// - Alignment: edge, or centre aligned with up, down or both matches.
// - Counter readable as low byte and two-bit high byte, upper bits zero.
// - Compare A low byte is read/write and resets to zero.
// - Channel A mode: compare, capture, PWM or single pulse, timer/counter.
// - Timer switching on zeroes the counter; switching off holds it.
// - Period value compares counter bits 9 to 7; zero means full 1024.
package etcp_pkg;
  localparam int ADDR_W = 8;
  localparam int CNT_W = 10;
  localparam logic [ADDR_W-1:0] OFS_TIMER_CTRL = 8'h00;
  localparam logic [ADDR_W-1:0] OFS_CHAN_A_CTRL = 8'h04;
  localparam logic [ADDR_W-1:0] OFS_CHAN_B_CTRL = 8'h08;
  localparam logic [ADDR_W-1:0] OFS_CNT_LOW = 8'h0C;
  localparam logic [ADDR_W-1:0] OFS_CNT_HIGH = 8'h10;
  localparam logic [ADDR_W-1:0] OFS_CMP_A_LOW = 8'h14;
  localparam logic [ADDR_W-1:0] OFS_CMP_A_HIGH = 8'h18;
  localparam logic [ADDR_W-1:0] OFS_CMP_B_LOW = 8'h1C;
  localparam logic [ADDR_W-1:0] OFS_CMP_B_HIGH = 8'h20;
  // Timer control: on bit and period compare value
  localparam int TC_ON_BIT = 3;
  localparam int TC_PERIOD_LSB = 0;
  // Channel control layout; bits 7 to 2 shared by both channels, bits 1 and 0 differ per channel
  localparam int CH_MODE_LSB = 6;
  localparam int CH_ACT_LSB = 4;
  localparam int CH_LEVEL_BIT = 3;
  localparam int CH_INV_BIT = 2;
  localparam int CHA_DIR_BIT = 1;
  localparam int CHA_CLR_BIT = 0;
  localparam int CHB_ALIGN_LSB = 0;
  localparam logic [7:0] TIMER_CTRL_RST = 8'h00;
  localparam logic [7:0] CHAN_CTRL_RST = 8'h00;
  localparam logic [9:0] CMP_RST = 10'h000;
  localparam logic [9:0] CNT_MAX = 10'h3FF;
  localparam int PERIOD_SHIFT = 7;
  typedef enum logic [1:0] {ETCP_CMP, ETCP_CAPT, ETCP_PWM, ETCP_TIMER} etcp_mode_t;
  typedef enum logic [1:0] {ETCP_EDGE, ETCP_CTR_UP, ETCP_CTR_DN, ETCP_CTR_BOTH} etcp_align_t;
endpackage

// [hdl/etcp_timer.sv]
// Enhanced timer: APB registers, 10-bit counter, compare/PWM/capture channels A and B
module etcp_timer
  import etcp_pkg::*;
(
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic i_ce,
  input wire logic i_psel,
  input wire logic i_penable,
  input wire logic i_pwrite,
  input wire logic [ADDR_W-1:0] i_paddr,
  input wire logic [31:0] i_pwdata,
  output logic [31:0] o_prdata,
  output logic o_pready,
  output logic o_pslverr,
  input wire logic i_chan_a_pin,
  output logic o_chan_a_pin,
  output logic o_chan_a_pin_oe,
  input wire logic [2:0] i_chan_b_pins,
  output logic [2:0] o_chan_b_pins,
  output logic [2:0] o_chan_b_pins_oe
);

  logic [7:0] timer_ctrl_q;
  logic [7:0] chan_a_ctrl_q;
  logic [7:0] chan_b_ctrl_q;
  logic [9:0] cmp_a_q;
  logic [9:0] cmp_b_q;
  logic [9:0] cnt_q;
  logic [9:0] cnt_d;
  logic dir_q;
  logic dir_d;
  logic on_prev_q;
  logic st_a_q;
  logic st_b_q;
  logic st_a_d;
  logic st_b_d;
  logic cap_a_prev_q;
  logic cap_b_prev_q;
  logic pready_q;
  logic [31:0] prdata_q;
  logic pslverr_q;

  etcp_mode_t mode_a;
  etcp_mode_t mode_b;
  etcp_align_t align;
  logic [1:0] act_a;
  logic [1:0] act_b;
  logic timer_on;
  logic on_rise;
  logic [2:0] period;
  logic [9:0] p_last;
  logic [9:0] top;
  logic match_a;
  logic match_b;
  logic single;
  logic use_a_clear;
  logic centre;
  logic cap_a_hit;
  logic cap_b_hit;
  logic setup;
  logic done;
  logic wr;
  logic mapped;

  // Capture edge decode shared by both channels
  function automatic logic cap_edge(input logic [1:0] act, input logic prev,
                                    input logic cur);
    logic hit;
    hit = 1'b0;
    case (act)
      2'b00: hit = cur & ~prev;
      2'b01: hit = ~cur & prev;
      2'b10: hit = cur ^ prev;
      default: hit = 1'b0;
    endcase
    return hit;
  endfunction

  // Next internal (pre-polarity) level of one channel
  function automatic logic chan_next(input etcp_mode_t mode, input logic [1:0] act,
                                     input logic lvl, input logic cur,
                                     input logic match, input logic lt,
                                     input logic rise);
    logic nx;
    nx = cur;
    case (mode)
      ETCP_CMP:
      begin
        if (rise)
          nx = lvl;
        else if (match)
        begin
          // Forcing a level already present is naturally a no-op
          case (act)
            2'b01: nx = 1'b0;
            2'b10: nx = 1'b1;
            2'b11: nx = ~cur;
            default: nx = cur;
          endcase
        end
      end
      ETCP_PWM:
      begin
        case (act)
          2'b00: nx = ~lvl;
          2'b01: nx = lvl;
          2'b10: nx = lt ? lvl : ~lvl;
          default:
          begin
            // Single pulse: active from switch-on until the first match
            if (rise)
              nx = lvl;
            else if (match)
              nx = ~lvl;
          end
        endcase
      end
      default: nx = cur;
    endcase
    return nx;
  endfunction

  assign mode_a = etcp_mode_t'(chan_a_ctrl_q[CH_MODE_LSB +: 2]);
  assign mode_b = etcp_mode_t'(chan_b_ctrl_q[CH_MODE_LSB +: 2]);
  assign act_a = chan_a_ctrl_q[CH_ACT_LSB +: 2];
  assign act_b = chan_b_ctrl_q[CH_ACT_LSB +: 2];
  assign align = etcp_align_t'(chan_b_ctrl_q[CHB_ALIGN_LSB +: 2]);
  assign timer_on = timer_ctrl_q[TC_ON_BIT];
  assign period = timer_ctrl_q[TC_PERIOD_LSB +: 3];
  assign on_rise = timer_on & ~on_prev_q;

  // Period match falls on counter bits 9..7; zero lets the counter wrap
  assign p_last = (period == 3'h0) ? CNT_MAX
                : 10'({period, 7'h00} - 10'h001);
  assign single = (mode_a == ETCP_PWM) && (act_a == 2'b11);
  assign use_a_clear = chan_a_ctrl_q[CHA_CLR_BIT] && !single
                       && (mode_a != ETCP_CAPT);
  assign top = use_a_clear ? cmp_a_q : p_last;
  assign centre = (mode_a == ETCP_PWM) && !single && (align != ETCP_EDGE);

  // Centre up and down modes only let a match count in the chosen direction; centre both lets either count
  always_comb
  begin
    match_a = (cnt_q == cmp_a_q);
    match_b = (cnt_q == cmp_b_q);
    if (centre)
    begin
      case (align)
        ETCP_CTR_UP:
        begin
          match_a = match_a & ~dir_q;
          match_b = match_b & ~dir_q;
        end
        ETCP_CTR_DN:
        begin
          match_a = match_a & dir_q;
          match_b = match_b & dir_q;
        end
        default:
        begin
          match_a = match_a;
          match_b = match_b;
        end
      endcase
    end
  end

  // Counter next value; comparator B never takes part in clearing
  always_comb
  begin
    cnt_d = cnt_q;
    dir_d = dir_q;
    if (on_rise)
    begin
      cnt_d = 10'h000;
      dir_d = 1'b0;
    end
    else if (timer_on)
    begin
      if (centre)
      begin
        if (!dir_q)
        begin
          if (cnt_q >= top)
          begin
            dir_d = 1'b1;
            cnt_d = 10'(cnt_q - 10'h001);
          end
          else
            cnt_d = 10'(cnt_q + 10'h001);
        end
        else
        begin
          if (cnt_q == 10'h000)
          begin
            dir_d = 1'b0;
            cnt_d = 10'h001;
          end
          else
            cnt_d = 10'(cnt_q - 10'h001);
        end
      end
      else if (cnt_q == top)
      begin
        cnt_d = 10'h000;
        dir_d = 1'b0;
      end
      else
        cnt_d = 10'(cnt_q + 10'h001);
    end
  end

  assign st_a_d = chan_next(mode_a, act_a, chan_a_ctrl_q[CH_LEVEL_BIT], st_a_q,
                            match_a && timer_on, cnt_q < cmp_a_q, on_rise);
  assign st_b_d = chan_next(mode_b, act_b, chan_b_ctrl_q[CH_LEVEL_BIT], st_b_q,
                            match_b && timer_on, cnt_q < cmp_b_q,
                            on_rise);

  assign cap_a_hit = timer_on && (mode_a == ETCP_CAPT)
                     && cap_edge(act_a, cap_a_prev_q, i_chan_a_pin);
  assign cap_b_hit = timer_on && (mode_b == ETCP_CAPT)
                     && cap_edge(act_b, cap_b_prev_q, i_chan_b_pins[0]);

  always_ff @(posedge i_clk or posedge i_rst)
  begin
    if (i_rst)
    begin
      cnt_q <= 10'h000;
      dir_q <= 1'b0;
      on_prev_q <= 1'b0;
    end
    else if (i_ce)
    begin
      cnt_q <= cnt_d;
      dir_q <= dir_d;
      on_prev_q <= timer_on;
    end
  end

  // Pin levels; outputs are registered, polarity applied last
  always_ff @(posedge i_clk or posedge i_rst)
  begin
    if (i_rst)
    begin
      st_a_q <= 1'b0;
      st_b_q <= 1'b0;
      cap_a_prev_q <= 1'b0;
      cap_b_prev_q <= 1'b0;
      o_chan_a_pin <= 1'b0;
      o_chan_a_pin_oe <= 1'b0;
      o_chan_b_pins <= 3'h0;
      o_chan_b_pins_oe <= 3'h0;
    end
    else if (i_ce)
    begin
      st_a_q <= st_a_d;
      st_b_q <= st_b_d;
      cap_a_prev_q <= i_chan_a_pin;
      cap_b_prev_q <= i_chan_b_pins[0];
      o_chan_a_pin <= (mode_a == ETCP_TIMER) ? 1'b0
                    : st_a_d ^ chan_a_ctrl_q[CH_INV_BIT];
      o_chan_a_pin_oe <= (mode_a == ETCP_CMP) || (mode_a == ETCP_PWM);
      o_chan_b_pins <= (mode_b == ETCP_TIMER) ? 3'h0
                     : {3{st_b_d ^ chan_b_ctrl_q[CH_INV_BIT]}};
      o_chan_b_pins_oe <= {3{(mode_b == ETCP_CMP) || (mode_b == ETCP_PWM)}};
    end
  end

  // APB: one access cycle, no wait states beyond the registered answer
  assign setup = i_psel && !i_penable;
  assign done = i_psel && i_penable && pready_q;
  assign wr = done && i_pwrite;

  always_comb
  begin
    case (i_paddr)
      OFS_TIMER_CTRL, OFS_CHAN_A_CTRL, OFS_CHAN_B_CTRL, OFS_CNT_LOW,
      OFS_CNT_HIGH, OFS_CMP_A_LOW, OFS_CMP_A_HIGH, OFS_CMP_B_LOW,
      OFS_CMP_B_HIGH: mapped = 1'b1;
      default: mapped = 1'b0;
    endcase
  end

  always_ff @(posedge i_clk or posedge i_rst)
  begin
    if (i_rst)
    begin
      timer_ctrl_q <= TIMER_CTRL_RST;
      chan_a_ctrl_q <= CHAN_CTRL_RST;
      chan_b_ctrl_q <= CHAN_CTRL_RST;
    end
    else if (i_ce && wr)
    begin
      case (i_paddr)
        OFS_TIMER_CTRL: timer_ctrl_q <= {4'h0, i_pwdata[3:0]};
        // Direction flag is hardware-owned; software writes to it are dropped
        OFS_CHAN_A_CTRL: chan_a_ctrl_q <= {i_pwdata[7:2], 1'b0,
                                           i_pwdata[CHA_CLR_BIT]};
        OFS_CHAN_B_CTRL: chan_b_ctrl_q <= i_pwdata[7:0];
        default: chan_a_ctrl_q <= chan_a_ctrl_q;
      endcase
    end
  end

  // Capture wins over a software write in the same cycle
  always_ff @(posedge i_clk or posedge i_rst)
  begin
    if (i_rst)
    begin
      cmp_a_q <= CMP_RST;
      cmp_b_q <= CMP_RST;
    end
    else if (i_ce)
    begin
      if (cap_a_hit)
        cmp_a_q <= cnt_q;
      else if (wr && i_paddr == OFS_CMP_A_LOW)
        cmp_a_q[7:0] <= i_pwdata[7:0];
      else if (wr && i_paddr == OFS_CMP_A_HIGH)
        cmp_a_q[9:8] <= i_pwdata[1:0];
      if (cap_b_hit)
        cmp_b_q <= cnt_q;
      else if (wr && i_paddr == OFS_CMP_B_LOW)
        cmp_b_q[7:0] <= i_pwdata[7:0];
      else if (wr && i_paddr == OFS_CMP_B_HIGH)
        cmp_b_q[9:8] <= i_pwdata[1:0];
    end
  end

  always_ff @(posedge i_clk or posedge i_rst)
  begin
    if (i_rst)
    begin
      pready_q <= 1'b0;
      prdata_q <= 32'h0000_0000;
      pslverr_q <= 1'b0;
    end
    else if (i_ce)
    begin
      pready_q <= setup;
      if (setup)
      begin
        pslverr_q <= !mapped;
        case (i_paddr)
          OFS_TIMER_CTRL: prdata_q <= {24'h000000, timer_ctrl_q};
          OFS_CHAN_A_CTRL: prdata_q <= {24'h000000, chan_a_ctrl_q[7:2], dir_q,
                                        chan_a_ctrl_q[CHA_CLR_BIT]};
          OFS_CHAN_B_CTRL: prdata_q <= {24'h000000, chan_b_ctrl_q};
          OFS_CNT_LOW: prdata_q <= {24'h000000, cnt_q[7:0]};
          OFS_CNT_HIGH: prdata_q <= {30'h00000000, cnt_q[9:8]};
          OFS_CMP_A_LOW: prdata_q <= {24'h000000, cmp_a_q[7:0]};
          OFS_CMP_A_HIGH: prdata_q <= {30'h00000000, cmp_a_q[9:8]};
          OFS_CMP_B_LOW: prdata_q <= {24'h000000, cmp_b_q[7:0]};
          OFS_CMP_B_HIGH: prdata_q <= {30'h00000000, cmp_b_q[9:8]};
          default: prdata_q <= 32'h0000_0000;
        endcase
      end
      else if (done)
      begin
        prdata_q <= 32'h0000_0000;
        pslverr_q <= 1'b0;
      end
    end
  end

  assign o_pready = pready_q;
  assign o_prdata = prdata_q;
  assign o_pslverr = pslverr_q;

endmodule // etcp_timer

// [sim/etcp_monitor.sv]
// Port-level checker for the enhanced timer
module etcp_monitor
  import etcp_pkg::*;
(
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic i_psel,
  input wire logic i_penable,
  input wire logic i_pwrite,
  input wire logic [ADDR_W-1:0] i_paddr,
  input wire logic [31:0] i_pwdata,
  input wire logic [31:0] o_prdata,
  input wire logic o_pready,
  input wire logic o_pslverr,
  input wire logic o_chan_a_pin,
  input wire logic o_chan_a_pin_oe,
  input wire logic [2:0] o_chan_b_pins,
  input wire logic [2:0] o_chan_b_pins_oe
);
  timeunit 1ns;
  timeprecision 1ns;
  logic acc, wr, rd, capt_q;
  logic [7:0] tc_q, ca_q, cb_q, cmpa_q;
  logic [1:0] st_q;
  assign acc = i_psel && i_penable && o_pready && !o_pslverr;
  assign wr = acc && i_pwrite;
  assign rd = acc && !i_pwrite;
  // Shadow of the control bytes; st_q counts quiet cycles since a control write
  always_ff @(posedge i_clk or posedge i_rst)
  begin
    if (i_rst)
    begin
      tc_q <= 8'h00;
      ca_q <= 8'h00;
      cb_q <= 8'h00;
      cmpa_q <= 8'h00;
      st_q <= 2'h0;
      capt_q <= 1'b0;
    end
    else
    begin
      if (wr && i_paddr == OFS_TIMER_CTRL) tc_q <= i_pwdata[7:0];
      if (wr && i_paddr == OFS_CHAN_A_CTRL) ca_q <= i_pwdata[7:0];
      if (wr && i_paddr == OFS_CHAN_B_CTRL) cb_q <= i_pwdata[7:0];
      if (wr && i_paddr == OFS_CMP_A_LOW) cmpa_q <= i_pwdata[7:0];
      if (wr && i_paddr < OFS_CNT_LOW) st_q <= 2'h0;
      else if (st_q != 2'h3) st_q <= st_q + 2'h1;
      // Once capture mode was seen, compare A no longer follows software alone
      if (ca_q[7:6] == 2'h1) capt_q <= 1'b1;
    end
  end
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_rst);
  property p_b_alike;
    o_chan_b_pins inside {3'h0, 3'h7} && o_chan_b_pins_oe inside {3'h0, 3'h7};
  endproperty
  a_b_alike: assert property (p_b_alike)
    else $error("chan b pins differ");
  property p_cnt_hi;
    rd && i_paddr == OFS_CNT_HIGH |-> o_prdata[31:2] == 30'h0;
  endproperty
  a_cnt_hi: assert property (p_cnt_hi)
    else $error("counter high upper bits set");
  property p_dir_up;
    rd && i_paddr == OFS_CHAN_A_CTRL && tc_q[3] && st_q == 2'h3 && cb_q[1:0] == 2'h0
      |-> !o_prdata[1];
  endproperty
  a_dir_up: assert property (p_dir_up)
    else $error("down flag in edge alignment");
  property p_oe_a;
    tc_q[3] && st_q == 2'h3 |-> o_chan_a_pin_oe == (ca_q[7:6] == 2'h0 || ca_q[7:6] == 2'h2);
  endproperty
  a_oe_a: assert property (p_oe_a)
    else $error("chan a enable wrong for mode");
  property p_oe_b;
    tc_q[3] && st_q == 2'h3 |-> o_chan_b_pins_oe == {3{cb_q[7:6] == 2'h0 || cb_q[7:6] == 2'h2}};
  endproperty
  a_oe_b: assert property (p_oe_b)
    else $error("chan b enable wrong for mode");
  property p_init;
    $rose(tc_q[3]) && ca_q[7:6] == 2'h0 && cmpa_q >= 8'h08
      |-> ##[0:3] o_chan_a_pin == (ca_q[3] ^ ca_q[2]);
  endproperty
  a_init: assert property (p_init)
    else $error("chan a not at initial level");
  property p_force;
    tc_q[3] && st_q == 2'h3 && ca_q[7:6] == 2'h2 && !ca_q[5]
      |-> o_chan_a_pin == ((ca_q[4] ~^ ca_q[3]) ^ ca_q[2]);
  endproperty
  a_force: assert property (p_force)
    else $error("forced pwm level wrong");
  property p_cmpa;
    rd && i_paddr == OFS_CMP_A_LOW && !capt_q |-> o_prdata[7:0] == cmpa_q;
  endproperty
  a_cmpa: assert property (p_cmpa)
    else $error("compare a low byte lost");
endmodule // etcp_monitor

// [sim/etcp_pins.sv]
// Far-side pin model driving the timer's capture inputs
module etcp_pins
(
  input wire logic i_clk,
  input wire logic i_lvl,
  output logic o_a_pin,
  output logic [2:0] o_b_pins
);
  timeunit 1ns;
  timeprecision 1ns;
  initial o_a_pin = 1'b0;
  initial o_b_pins = 3'h2;
  // Pins 2:1 are no capture source, so they churn every cycle to expose misuse
  always @(posedge i_clk)
  begin
    o_a_pin <= i_lvl;
    o_b_pins <= {~o_b_pins[2], o_b_pins[2], i_lvl};
  end
endmodule // etcp_pins

// [sim/test_enhanced_timer_compare_pwm_capture.sv]
// Self-checking bench for the enhanced timer
module test_enhanced_timer_compare_pwm_capture;
  timeunit 1ns;
  timeprecision 1ns;
  import etcp_pkg::*;
  logic clk = 1'b0, rst = 1'b1, psel = 1'b0, pen = 1'b0, pwr = 1'b0, lvl = 1'b0;
  logic ce = 1'b1;
  logic [ADDR_W-1:0] paddr = '0;
  logic [31:0] pwdata = '0, prdata, rdv, lim, c1, c2, b1, b2;
  logic [31:0] rnd = 32'h00000045;
  logic pready, pslverr, slv, apin, apin_oe, a_in, seen, inv;
  logic [2:0] bpins, b_in, bpins_oe;
  int num_errors = 0, n_compared = 0, cnt;
  always #5 clk = ~clk;
  etcp_timer uut (.i_clk(clk), .i_rst(rst), .i_ce(ce), .i_psel(psel), .i_penable(pen),
    .i_pwrite(pwr), .i_paddr(paddr), .i_pwdata(pwdata), .o_prdata(prdata), .o_pready(pready),
    .o_pslverr(pslverr), .i_chan_a_pin(a_in), .o_chan_a_pin(apin), .o_chan_a_pin_oe(apin_oe),
    .i_chan_b_pins(b_in), .o_chan_b_pins(bpins), .o_chan_b_pins_oe(bpins_oe));
  etcp_pins far (.i_clk(clk), .i_lvl(lvl), .o_a_pin(a_in), .o_b_pins(b_in));
  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] x;
    x = s ^ (s << 13);
    x = x ^ (x >> 17);
    return x ^ (x << 5);
  endfunction
  function automatic logic cmp_pin(input logic [1:0] act, input logic lv, input logic iv);
    case (act)
      2'h0: return lv ^ iv;
      2'h1: return iv;
      2'h2: return ~iv;
      default: return ~lv ^ iv;
    endcase
  endfunction
  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    n_compared++;
    if (got !== exp)
    begin
      num_errors++;
      $display("wrong value %s expected %h seen %h", nm, exp, got);
    end
  endtask
  // Whole APB transfer, then one idle cycle so no signal is assigned twice at an edge
  task automatic apb(input logic w, input logic [ADDR_W-1:0] a, input logic [31:0] d);
    int n;
    n = 0;
    psel <= 1'b1;
    pwr <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    pen <= 1'b1;
    do
    begin
      @(posedge clk);
      n++;
    end
    while (pready !== 1'b1 && n < 20);
    if (pready !== 1'b1) num_errors++;
    rdv = prdata;
    slv = pslverr;
    psel <= 1'b0;
    pen <= 1'b0;
    @(posedge clk);
  endtask
  task automatic wr(input logic [ADDR_W-1:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask
  task automatic wt(input int n);
    repeat (n) @(posedge clk);
  endtask
  task automatic final_report;
    $display("compared %0d mismatches %0d", n_compared, num_errors);
    if (num_errors == 0 && n_compared > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  initial
  begin
    #1000000;
    num_errors++;
    final_report();
  end
  initial
  begin
    wt(8);
    rst <= 1'b0;
    wt(1);
    for (int i = 0; i < 10; i++)
    begin
      apb(1'b0, ADDR_W'(i * 4), 32'h0);
      chk("reset value", 32'h0, rdv);
      chk("slave error", i == 9, slv);
    end
    wr(OFS_CMP_A_LOW, 32'h10);
    apb(1'b0, OFS_CMP_A_LOW, 32'h0);
    chk("compare a low", 32'h10, rdv);
    wr(OFS_CMP_B_LOW, 32'h10);
    // Timer is always off before mode or action changes
    for (int k = 0; k < 16; k++)
    begin
      wr(OFS_TIMER_CTRL, 32'h0);
      wr(OFS_CHAN_A_CTRL, k << 2);
      wr(OFS_CHAN_B_CTRL, k << 2);
      wr(OFS_TIMER_CTRL, 32'h8);
      wt(4);
      chk("initial a", k[1] ^ k[0], apin);
      wt(20);
      chk("match a", cmp_pin(k[3:2], k[1], k[0]), apin);
      chk("match b", {3{cmp_pin(k[3:2], k[1], k[0])}}, bpins);
    end
    for (int j = 0; j < 2; j++)
    begin
      rnd = xs(rnd);
      lim = j ? 32'h7F : 32'h14 + rnd[5:0];
      wr(OFS_TIMER_CTRL, 32'h0);
      wr(OFS_CMP_A_LOW, j ? 32'hC8 : lim);
      wr(OFS_CHAN_A_CTRL, 32'h1 - j);
      wr(OFS_TIMER_CTRL, 32'h8 + j);
      repeat (40)
      begin
        rnd = xs(rnd);
        wt(rnd[3:0]);
        apb(1'b0, OFS_CNT_LOW, 32'h0);
        chk("cleared count", 1, rdv <= lim);
      end
    end
    wr(OFS_TIMER_CTRL, 32'h0);
    apb(1'b0, OFS_CNT_LOW, 32'h0);
    c1 = rdv;
    wt(20);
    apb(1'b0, OFS_CNT_LOW, 32'h0);
    chk("held count", c1, rdv);
    wr(OFS_TIMER_CTRL, 32'h8);
    wr(OFS_TIMER_CTRL, 32'h0);
    apb(1'b0, OFS_CNT_LOW, 32'h0);
    // Zeroed on switch-on, then two running edges before the off write lands
    chk("restart count", 32'h2, rdv);
    wr(OFS_CMP_A_LOW, 32'h10);
    for (int p = 0; p < 8; p++)
    begin
      rnd = xs(rnd);
      inv = rnd[0];
      wr(OFS_TIMER_CTRL, 32'h0);
      wr(OFS_CHAN_A_CTRL, 32'h80 | (p << 3) | (inv << 2));
      wr(OFS_CHAN_B_CTRL, 32'h80 | (p << 3) | (inv << 2));
      wr(OFS_TIMER_CTRL, 32'h9);
      wt(2);
      cnt = 0;
      repeat (256)
      begin
        @(posedge clk);
        cnt += (apin === (p[0] ^ inv));
      end
      if (p < 6)
        chk("pwm active", p < 2 ? 0 : p < 4 ? 256 : 32, cnt);
      else
        chk("pulse", 1, cnt > 8 && cnt <= 16);
    end
    for (int al = 0; al < 4; al++)
    begin
      wr(OFS_TIMER_CTRL, 32'h0);
      wr(OFS_CHAN_A_CTRL, 32'hA8);
      wr(OFS_CHAN_B_CTRL, 32'hA0 | al);
      wr(OFS_TIMER_CTRL, 32'h9);
      seen = 1'b0;
      repeat (100)
      begin
        apb(1'b0, OFS_CHAN_A_CTRL, 32'h0);
        seen |= rdv[1];
      end
      chk("down seen", al != 0, seen);
    end
    for (int c = 0; c < 4; c++)
    begin
      wr(OFS_TIMER_CTRL, 32'h0);
      wr(OFS_CMP_A_LOW, 32'h0);
      wr(OFS_CMP_B_LOW, 32'h0);
      wr(OFS_CHAN_A_CTRL, 32'h40 | (c << 4));
      wr(OFS_CHAN_B_CTRL, 32'h40 | (c << 4));
      wr(OFS_TIMER_CTRL, 32'h8);
      wt(10);
      lvl <= 1'b1;
      wt(10);
      apb(1'b0, OFS_CMP_A_LOW, 32'h0);
      c1 = rdv;
      apb(1'b0, OFS_CMP_B_LOW, 32'h0);
      b1 = rdv;
      lvl <= 1'b0;
      wt(10);
      apb(1'b0, OFS_CMP_A_LOW, 32'h0);
      c2 = rdv;
      apb(1'b0, OFS_CMP_B_LOW, 32'h0);
      b2 = rdv;
      chk("capture a", {c == 1 || c == 2, c == 0 || c == 2}, {c2 != c1, c1 != 0});
      chk("capture b", {c == 1 || c == 2, c == 0 || c == 2}, {b2 != b1, b1 != 0});
      chk("capture oe", 32'h0, {apin_oe, bpins_oe});
    end
    wr(OFS_TIMER_CTRL, 32'h0);
    wr(OFS_CHAN_A_CTRL, 32'hC0);
    wr(OFS_CHAN_B_CTRL, 32'hC0);
    wr(OFS_TIMER_CTRL, 32'h8);
    wt(4);
    chk("timer mode oe", 32'h0, {apin_oe, bpins_oe});
    // Clock enable low must freeze the running counter; three edges run before it drops
    apb(1'b0, OFS_CNT_LOW, 32'h0);
    c1 = rdv;
    ce <= 1'b0;
    wt(50);
    ce <= 1'b1;
    apb(1'b0, OFS_CNT_LOW, 32'h0);
    chk("frozen count", (c1 + 32'h3) & 32'hFF, rdv);
    final_report();
  end
endmodule // test_enhanced_timer_compare_pwm_capture
bind etcp_timer etcp_monitor chk_i (.i_clk, .i_rst, .i_psel, .i_penable, .i_pwrite, .i_paddr,
  .i_pwdata, .o_prdata, .o_pready, .o_pslverr, .o_chan_a_pin, .o_chan_a_pin_oe,
  .o_chan_b_pins, .o_chan_b_pins_oe);
